// ===== core/lsd_decoder.sv
module lsd_decoder (
  input  wire logic                CLK_SYS,
  input  wire logic                RSTN,
  input  wire lsd_pkg::lsd_instr_s INSTR,
  input  wire logic                PROT_MODE,
  input  wire logic                IO_PRIV_OK,
  input  wire logic                ADDR32,
  input  wire logic [31:0]         COUNT_REG,
  input  wire logic                ELEM_MISMATCH,
  output logic                     ACCEPT,
  output lsd_pkg::lsd_dec_s        RESULT,
  output logic                     BUSY,
  output logic                     STEP,
  output logic                     DONE,
  output logic [31:0]              CLOCKS_USED,
  output logic [31:0]              ITER_LEFT
);

  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_EXEC      = 2'h1,
    ST_REP_SETUP = 2'h2,
    ST_REP_ITER  = 2'h3
  } lsd_state_e;

  lsd_state_e        state;
  lsd_state_e        next_state;
  lsd_pkg::lsd_dec_s dec;
  logic [7:0]        dec_cycles;
  logic              take;
  logic              timer_load;
  logic [7:0]        timer_val;
  logic              expire;
  logic [31:0]       count_in;
  logic [7:0]        opc;
  logic [1:0]        mod_f;
  logic [2:0]        sub_f;
  logic [2:0]        fn_f;
  logic              reg_form;
  logic              w_bit;
  logic              d_bit;

  assign opc      = INSTR.opcode;
  assign mod_f    = INSTR.modrm[lsd_pkg::MODRM_MOD_MSB:lsd_pkg::MODRM_MOD_LSB];
  assign sub_f    = INSTR.modrm[lsd_pkg::MODRM_SUB_MSB:lsd_pkg::MODRM_SUB_LSB];
  assign fn_f     = opc[lsd_pkg::OPC_FN_MSB:lsd_pkg::OPC_FN_LSB];
  assign reg_form = (mod_f == lsd_pkg::MOD_REGISTER);
  assign w_bit    = opc[lsd_pkg::OPC_W_BIT];
  assign d_bit    = opc[lsd_pkg::OPC_D_BIT];

  // Operation, operand form and clock count of the presented opcode
  always_comb begin
    dec               = '0;
    dec.op            = lsd_pkg::OP_NONE;
    dec.form          = lsd_pkg::FORM_NONE;
    dec.byte_op       = !w_bit;
    dec.illegal       = 1'b1;
    dec_cycles        = lsd_pkg::CYC_ILLEGAL;
    if ((opc & lsd_pkg::OPC_LOGIC_RM_MASK) == lsd_pkg::OPC_LOGIC_RM_VAL) begin
      case (fn_f)
        lsd_pkg::FN_AND: dec.op = lsd_pkg::OP_AND;
        lsd_pkg::FN_OR:  dec.op = lsd_pkg::OP_OR;
        lsd_pkg::FN_XOR: dec.op = lsd_pkg::OP_XOR;
        default:         dec.op = lsd_pkg::OP_NONE;
      endcase
      dec.illegal       = (dec.op == lsd_pkg::OP_NONE);
      dec.writes_result = 1'b1;
      dec.dest_is_rm    = !d_bit;
      if (reg_form) begin
        dec.form   = lsd_pkg::FORM_REG_REG;
        dec_cycles = lsd_pkg::CYC_REG;
      end else if (!d_bit) begin
        dec.form        = lsd_pkg::FORM_REG_TO_MEM;
        dec.mem_operand = 1'b1;
        dec_cycles      = lsd_pkg::CYC_REG_TO_MEM;
      end else begin
        dec.form        = lsd_pkg::FORM_MEM_TO_REG;
        dec.mem_operand = 1'b1;
        dec_cycles      = lsd_pkg::CYC_MEM_TO_REG;
      end
    end else if ((opc & lsd_pkg::OPC_LOGIC_ACC_MASK) == lsd_pkg::OPC_LOGIC_ACC_VAL) begin
      case (fn_f)
        lsd_pkg::FN_AND: dec.op = lsd_pkg::OP_AND;
        lsd_pkg::FN_OR:  dec.op = lsd_pkg::OP_OR;
        lsd_pkg::FN_XOR: dec.op = lsd_pkg::OP_XOR;
        default:         dec.op = lsd_pkg::OP_NONE;
      endcase
      dec.illegal       = (dec.op == lsd_pkg::OP_NONE);
      dec.form          = lsd_pkg::FORM_IMM_ACC;
      dec.writes_result = 1'b1;
      dec_cycles        = lsd_pkg::CYC_REG;
    end else begin
      case (opc & lsd_pkg::OPC_W_CLEAR_MASK)
        lsd_pkg::OPC_GROUP_IMM: begin
          case (sub_f)
            lsd_pkg::FN_AND: dec.op = lsd_pkg::OP_AND;
            lsd_pkg::FN_OR:  dec.op = lsd_pkg::OP_OR;
            lsd_pkg::FN_XOR: dec.op = lsd_pkg::OP_XOR;
            default:         dec.op = lsd_pkg::OP_NONE;
          endcase
          dec.illegal       = (dec.op == lsd_pkg::OP_NONE);
          dec.form          = lsd_pkg::FORM_IMM_RM;
          dec.dest_is_rm    = 1'b1;
          dec.writes_result = 1'b1;
          dec.mem_operand   = !reg_form;
          dec_cycles        = reg_form ? lsd_pkg::CYC_REG
                                       : lsd_pkg::CYC_IMM_TO_MEM;
        end
        lsd_pkg::OPC_TEST_RM: begin
          dec.op          = lsd_pkg::OP_TEST;
          dec.illegal     = 1'b0;
          dec.form        = reg_form ? lsd_pkg::FORM_REG_REG : lsd_pkg::FORM_MEM_TO_REG;
          dec.mem_operand = !reg_form;
          dec_cycles      = reg_form ? lsd_pkg::CYC_REG : lsd_pkg::CYC_TEST_MEM;
        end
        lsd_pkg::OPC_GROUP_UNARY: begin
          dec.mem_operand = !reg_form;
          dec.dest_is_rm  = 1'b1;
          if (sub_f == lsd_pkg::SUB_TEST) begin
            dec.op      = lsd_pkg::OP_TEST;
            dec.illegal = 1'b0;
            dec.form    = lsd_pkg::FORM_IMM_RM;
            dec_cycles  = reg_form ? lsd_pkg::CYC_REG : lsd_pkg::CYC_TEST_MEM;
          end else if (sub_f == lsd_pkg::SUB_INVERT) begin
            dec.op            = lsd_pkg::OP_INVERT;
            dec.illegal       = 1'b0;
            dec.form          = lsd_pkg::FORM_UNARY_RM;
            dec.writes_result = 1'b1;
            dec_cycles        = reg_form ? lsd_pkg::CYC_REG
                                         : lsd_pkg::CYC_INVERT_MEM;
          end
        end
        lsd_pkg::OPC_TEST_ACC: begin
          dec.op      = lsd_pkg::OP_TEST;
          dec.illegal = 1'b0;
          dec.form    = lsd_pkg::FORM_IMM_ACC;
          dec_cycles  = lsd_pkg::CYC_REG;
        end
        lsd_pkg::OPC_COMPARE_STRING: begin
          dec.op       = lsd_pkg::OP_COMPARE_STRING;
          dec.illegal  = 1'b0;
          dec.form     = lsd_pkg::FORM_STRING;
          dec.repeated = INSTR.repeat_while_equal_prefix;
          dec_cycles   = dec.repeated ? lsd_pkg::CYC_REPEAT_SETUP
                                      : lsd_pkg::CYC_COMPARE_STRING;
        end
        lsd_pkg::OPC_PORT_IN_STRING: begin
          dec.op            = lsd_pkg::OP_PORT_INPUT_STRING;
          dec.illegal       = 1'b0;
          dec.form          = lsd_pkg::FORM_STRING;
          dec.writes_result = 1'b1;
          if (!PROT_MODE) begin
            dec_cycles = lsd_pkg::CYC_PORT_IN_REAL;
          end else if (IO_PRIV_OK) begin
            dec_cycles = lsd_pkg::CYC_PORT_IN_PROT;
          end else begin
            dec_cycles = lsd_pkg::CYC_PORT_IN_TRAP;
          end
        end
        lsd_pkg::OPC_LOAD_STRING: begin
          dec.op            = lsd_pkg::OP_LOAD_STRING;
          dec.illegal       = 1'b0;
          dec.form          = lsd_pkg::FORM_STRING;
          dec.writes_result = 1'b1;
          dec_cycles        = lsd_pkg::CYC_LOAD_STRING;
        end
        lsd_pkg::OPC_MOVE_STRING: begin
          dec.op            = lsd_pkg::OP_MOVE_STRING;
          dec.illegal       = 1'b0;
          dec.form          = lsd_pkg::FORM_STRING;
          dec.writes_result = 1'b1;
          dec_cycles        = lsd_pkg::CYC_MOVE_STRING;
        end
        lsd_pkg::OPC_PORT_OUT_STRING: begin
          dec.op      = lsd_pkg::OP_PORT_OUTPUT_STRING;
          dec.illegal = 1'b0;
          dec.form    = lsd_pkg::FORM_STRING;
          if (!PROT_MODE) begin
            dec_cycles = lsd_pkg::CYC_PORT_OUT_REAL;
          end else if (IO_PRIV_OK) begin
            dec_cycles = lsd_pkg::CYC_PORT_OUT_PROT;
          end else begin
            dec_cycles = lsd_pkg::CYC_PORT_OUT_TRAP;
          end
        end
        lsd_pkg::OPC_SCAN_STRING: begin
          dec.op      = lsd_pkg::OP_SCAN_STRING;
          dec.illegal = 1'b0;
          dec.form    = lsd_pkg::FORM_STRING;
          dec_cycles  = lsd_pkg::CYC_SCAN_STRING;
        end
        lsd_pkg::OPC_STORE_STRING: begin
          dec.op            = lsd_pkg::OP_STORE_STRING;
          dec.illegal       = 1'b0;
          dec.form          = lsd_pkg::FORM_STRING;
          dec.writes_result = 1'b1;
          dec_cycles        = lsd_pkg::CYC_STORE_STRING;
        end
        default: begin
          if (opc == lsd_pkg::OPC_TABLE_LOOKUP) begin
            dec.op            = lsd_pkg::OP_TABLE_LOOKUP;
            dec.illegal       = 1'b0;
            dec.byte_op       = 1'b1;
            dec.form          = lsd_pkg::FORM_STRING;
            dec.writes_result = 1'b1;
            dec_cycles        = lsd_pkg::CYC_TABLE_LOOKUP;
          end
        end
      endcase
    end
  end

  // Iteration count comes from the low half of the count register in 16-bit addressing
  assign count_in = ADDR32 ? COUNT_REG : {16'h0000, COUNT_REG[15:0]};

  assign ACCEPT = (state == ST_IDLE) ? 1'b1 : 1'b0;
  assign take   = INSTR.valid && ACCEPT;
  assign BUSY   = !ACCEPT;

  // Instruction ends on the last clock of its final phase
  always_comb begin
    DONE = 1'b0;
    STEP = 1'b0;
    case (state)
      ST_EXEC:      DONE = expire;
      ST_REP_SETUP: DONE = expire && (ITER_LEFT == 32'h0000_0000);
      ST_REP_ITER: begin
        STEP = expire;
        DONE = expire && (ELEM_MISMATCH || ITER_LEFT == 32'h0000_0001);
      end
      default: begin
        DONE = 1'b0;
        STEP = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = dec.repeated ? ST_REP_SETUP : ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (DONE) begin
          next_state = ST_IDLE;
        end
      end
      ST_REP_SETUP: begin
        if (DONE) begin
          next_state = ST_IDLE;
        end else if (expire) begin
          next_state = ST_REP_ITER;
        end
      end
      ST_REP_ITER: begin
        if (DONE) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Each compare iteration costs a fresh timer load
  always_comb begin
    timer_load = 1'b0;
    timer_val  = dec_cycles;
    if (take) begin
      timer_load = 1'b1;
    end else if (expire && !DONE && state != ST_EXEC) begin
      timer_load = 1'b1;
      timer_val  = lsd_pkg::CYC_REPEAT_ITER;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RESULT <= '0;
    end else if (take) begin
      RESULT <= dec;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ITER_LEFT <= 32'h0000_0000;
    end else if (take) begin
      ITER_LEFT <= dec.repeated ? count_in : 32'h0000_0000;
    end else if (STEP) begin
      ITER_LEFT <= ITER_LEFT - 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CLOCKS_USED <= 32'h0000_0000;
    end else if (take) begin
      CLOCKS_USED <= 32'h0000_0000;
    end else if (BUSY) begin
      CLOCKS_USED <= CLOCKS_USED + 32'h0000_0001;
    end
  end

  lsd_timer u_timer (
    .clk      (CLK_SYS),
    .rstn     (RSTN),
    .load     (timer_load),
    .load_val (timer_val),
    .expire   (expire)
  );

endmodule

// ===== core/lsd_timer.sv
module lsd_timer (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic            expire
);

  logic [7:0] remaining;

  // Counts the clocks of one phase; expire marks its last clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remaining <= 8'h00;
    end else if (load) begin
      remaining <= load_val;
    end else if (remaining != 8'h00) begin
      remaining <= remaining - 8'h01;
    end
  end

  assign expire = (remaining == 8'h01);

endmodule

// ===== shared/lsd_pkg.sv
package lsd_pkg;

  // Opcode patterns, compared after masking; the table lookup opcode is compared whole
  localparam logic [7:0] OPC_LOGIC_RM_MASK   = 8'hc4;
  localparam logic [7:0] OPC_LOGIC_RM_VAL    = 8'h00;
  localparam logic [7:0] OPC_LOGIC_ACC_MASK  = 8'hc6;
  localparam logic [7:0] OPC_LOGIC_ACC_VAL   = 8'h04;
  localparam logic [7:0] OPC_GROUP_IMM       = 8'h80;
  localparam logic [7:0] OPC_TEST_RM         = 8'h84;
  localparam logic [7:0] OPC_GROUP_UNARY     = 8'hf6;
  localparam logic [7:0] OPC_TEST_ACC        = 8'ha8;
  localparam logic [7:0] OPC_COMPARE_STRING  = 8'ha6;
  localparam logic [7:0] OPC_PORT_IN_STRING  = 8'h6c;
  localparam logic [7:0] OPC_LOAD_STRING     = 8'hac;
  localparam logic [7:0] OPC_MOVE_STRING     = 8'ha4;
  localparam logic [7:0] OPC_PORT_OUT_STRING = 8'h6e;
  localparam logic [7:0] OPC_SCAN_STRING     = 8'hae;
  localparam logic [7:0] OPC_STORE_STRING    = 8'haa;
  localparam logic [7:0] OPC_TABLE_LOOKUP    = 8'hd7;
  localparam logic [7:0] OPC_W_CLEAR_MASK    = 8'hfe;

  // Opcode and operand-byte field positions
  localparam int OPC_W_BIT    = 0;
  localparam int OPC_D_BIT    = 1;
  localparam int OPC_FN_LSB   = 3;
  localparam int OPC_FN_MSB   = 5;
  localparam int MODRM_SUB_LSB = 3;
  localparam int MODRM_SUB_MSB = 5;
  localparam int MODRM_MOD_LSB = 6;
  localparam int MODRM_MOD_MSB = 7;
  localparam logic [1:0] MOD_REGISTER = 2'h3;

  // Function codes in opcode bits 5:3 and operand subcodes
  localparam logic [2:0] FN_AND = 3'h4;
  localparam logic [2:0] FN_OR  = 3'h1;
  localparam logic [2:0] FN_XOR = 3'h6;
  localparam logic [2:0] SUB_TEST = 3'h0;
  localparam logic [2:0] SUB_INVERT = 3'h2;

  localparam logic [7:0] REPEAT_WHILE_EQUAL_PREFIX = 8'hf3;

  // Execution clock counts
  localparam logic [7:0] CYC_ILLEGAL        = 8'h01;
  localparam logic [7:0] CYC_REG            = 8'h02;
  localparam logic [7:0] CYC_REG_TO_MEM     = 8'h07;
  localparam logic [7:0] CYC_MEM_TO_REG     = 8'h06;
  localparam logic [7:0] CYC_IMM_TO_MEM     = 8'h07;
  localparam logic [7:0] CYC_TEST_MEM       = 8'h05;
  localparam logic [7:0] CYC_INVERT_MEM     = 8'h06;
  localparam logic [7:0] CYC_COMPARE_STRING = 8'h0a;
  localparam logic [7:0] CYC_PORT_IN_REAL   = 8'h0f;
  localparam logic [7:0] CYC_PORT_IN_PROT   = 8'h09;
  localparam logic [7:0] CYC_PORT_IN_TRAP   = 8'h1d;
  localparam logic [7:0] CYC_PORT_OUT_REAL  = 8'h0e;
  localparam logic [7:0] CYC_PORT_OUT_PROT  = 8'h08;
  localparam logic [7:0] CYC_PORT_OUT_TRAP  = 8'h1c;
  localparam logic [7:0] CYC_LOAD_STRING    = 8'h05;
  localparam logic [7:0] CYC_MOVE_STRING    = 8'h07;
  localparam logic [7:0] CYC_SCAN_STRING    = 8'h07;
  localparam logic [7:0] CYC_STORE_STRING   = 8'h04;
  localparam logic [7:0] CYC_TABLE_LOOKUP   = 8'h05;
  localparam logic [7:0] CYC_REPEAT_SETUP   = 8'h05;
  localparam logic [7:0] CYC_REPEAT_ITER    = 8'h09;

  typedef enum logic [3:0] {
    OP_NONE                 = 4'h0,
    OP_AND                  = 4'h1,
    OP_TEST                 = 4'h2,
    OP_OR                   = 4'h3,
    OP_XOR                  = 4'h4,
    OP_INVERT               = 4'h5,
    OP_COMPARE_STRING       = 4'h6,
    OP_PORT_INPUT_STRING    = 4'h7,
    OP_LOAD_STRING          = 4'h8,
    OP_MOVE_STRING          = 4'h9,
    OP_PORT_OUTPUT_STRING   = 4'ha,
    OP_SCAN_STRING          = 4'hb,
    OP_STORE_STRING         = 4'hc,
    OP_TABLE_LOOKUP         = 4'hd
  } lsd_op_e;

  typedef enum logic [2:0] {
    FORM_NONE       = 3'h0,
    FORM_REG_REG    = 3'h1,
    FORM_REG_TO_MEM = 3'h2,
    FORM_MEM_TO_REG = 3'h3,
    FORM_IMM_RM     = 3'h4,
    FORM_IMM_ACC    = 3'h5,
    FORM_UNARY_RM   = 3'h6,
    FORM_STRING     = 3'h7
  } lsd_form_e;

  typedef struct packed {
    logic       valid;
    logic       repeat_while_equal_prefix;
    logic [7:0] opcode;
    logic [7:0] modrm;
  } lsd_instr_s;

  typedef struct packed {
    lsd_op_e   op;
    lsd_form_e form;
    logic      byte_op;
    logic      dest_is_rm;
    logic      mem_operand;
    logic      writes_result;
    logic      repeated;
    logic      illegal;
  } lsd_dec_s;

endpackage

// ===== test/lsd_decoder_sva.sv
module lsd_decoder_sva (
  input wire logic                CLK_SYS,
  input wire logic                RSTN,
  input wire lsd_pkg::lsd_instr_s INSTR,
  input wire logic                PROT_MODE,
  input wire logic                IO_PRIV_OK,
  input wire logic                ADDR32,
  input wire logic [31:0]         COUNT_REG,
  input wire logic                ELEM_MISMATCH,
  input wire logic                ACCEPT,
  input wire lsd_pkg::lsd_dec_s   RESULT,
  input wire logic                BUSY,
  input wire logic                STEP,
  input wire logic                DONE,
  input wire logic [31:0]         CLOCKS_USED,
  input wire logic [31:0]         ITER_LEFT
);
  timeunit 1ns;
  timeprecision 1ps;

  logic take;
  logic rep_cmp;
  logic cnt_zero;

  assign take = INSTR.valid && ACCEPT;
  assign rep_cmp = INSTR.repeat_while_equal_prefix && INSTR.opcode[7:1] == 7'h53;
  assign cnt_zero = ADDR32 ? (COUNT_REG == 32'h0) : (COUNT_REG[15:0] == 16'h0);

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  a_take_busy: assert property (take |=> BUSY && !ACCEPT && CLOCKS_USED == 32'h0)
    else $error("take did not start a busy period");
  a_done_frees: assert property (DONE |=> ACCEPT && !BUSY)
    else $error("not idle after done");
  a_busy_counts: assert property (BUSY && !DONE |=> CLOCKS_USED == $past(CLOCKS_USED) + 32'h1)
    else $error("clock counter did not advance");
  a_result_holds: assert property (BUSY |=> $stable(RESULT))
    else $error("result changed while busy");
  a_compare_ten: assert property (
    take && !INSTR.repeat_while_equal_prefix && INSTR.opcode[7:1] == 7'h53
    |=> (!DONE) [*8] ##1 !DONE ##1 DONE) else $error("single compare not ten clocks");
  a_store_four: assert property (take && INSTR.opcode[7:1] == 7'h55
    |=> (!DONE) [*3] ##1 DONE) else $error("store not four clocks");
  a_port_in_real: assert property (take && INSTR.opcode[7:1] == 7'h36 && !PROT_MODE
    |=> (!DONE) [*8] ##1 (!DONE) [*6] ##1 DONE) else $error("real port input not 15");
  a_acc_short_two: assert property (take && (INSTR.opcode & 8'hc6) == 8'h04
    && INSTR.opcode[5:3] inside {3'h4, 3'h1, 3'h6} |=> !DONE ##1 DONE)
    else $error("short accumulator form not two clocks");
  a_repeat_zero: assert property (take && rep_cmp && cnt_zero
    |=> (!DONE) [*4] ##1 DONE) else $error("zero count repeat not five clocks");
  a_iter_nine: assert property (STEP && !DONE |=> (!STEP) [*8] ##1 STEP)
    else $error("repeat iteration not nine clocks");
  a_iter_dec: assert property (STEP && !DONE |=> ITER_LEFT == $past(ITER_LEFT) - 32'h1)
    else $error("iteration count did not decrement");
  a_mismatch_stop: assert property (STEP && ELEM_MISMATCH |-> DONE)
    else $error("repeat did not stop on mismatch");

  c_repeat_take: cover property (take && rep_cmp);
  c_iter_step: cover property (STEP && !DONE);
  c_illegal_done: cover property (DONE && RESULT.illegal);
endmodule

bind lsd_decoder lsd_decoder_sva u_sva (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .INSTR(INSTR), .PROT_MODE(PROT_MODE),
  .IO_PRIV_OK(IO_PRIV_OK), .ADDR32(ADDR32), .COUNT_REG(COUNT_REG),
  .ELEM_MISMATCH(ELEM_MISMATCH), .ACCEPT(ACCEPT), .RESULT(RESULT), .BUSY(BUSY),
  .STEP(STEP), .DONE(DONE), .CLOCKS_USED(CLOCKS_USED), .ITER_LEFT(ITER_LEFT)
);

// ===== test/lsd_decoder_tb.sv
module lsd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] opc;
    logic       mem;
    logic [2:0] sub;
    logic [1:0] mode;
    logic [3:0] op;
    logic [7:0] n;
  } lsd_case_s;

  typedef struct packed {
    logic [3:0]  op;
    logic [31:0] n;
    logic        byte_op;
    logic        chk;
    logic        dest;
    logic        chk_dest;
    logic        rep;
  } lsd_exp_s;

  logic                CLK_SYS;
  logic                RSTN;
  lsd_pkg::lsd_instr_s INSTR;
  logic                PROT_MODE;
  logic                IO_PRIV_OK;
  logic                ADDR32;
  logic [31:0]         COUNT_REG;
  logic                ELEM_MISMATCH;
  logic                ACCEPT;
  lsd_pkg::lsd_dec_s   RESULT;
  logic                BUSY;
  logic                STEP;
  logic                DONE;
  logic [31:0]         CLOCKS_USED;
  logic [31:0]         ITER_LEFT;
  int                  n_mismatch;
  int                  comparisons;
  int                  cycles;
  int                  nrep;
  lsd_exp_s            exp_q [$];
  lsd_exp_s            got;
  lsd_case_s           c;
  logic [31:0]         r;
  logic [7:0]          opc;
  logic [1:0]          mode;

  // Mode 3 means any mode, picked at random
  lsd_case_s cases [0:37] = '{
    '{8'h20,1'h1,3'h0,2'h3,4'h1,8'h07}, '{8'h22,1'h1,3'h0,2'h3,4'h1,8'h06},
    '{8'h80,1'h0,3'h4,2'h3,4'h1,8'h02}, '{8'h80,1'h1,3'h4,2'h3,4'h1,8'h07},
    '{8'h24,1'h1,3'h0,2'h3,4'h1,8'h02}, '{8'ha8,1'h1,3'h0,2'h3,4'h2,8'h02},
    '{8'h84,1'h0,3'h0,2'h3,4'h2,8'h02}, '{8'h84,1'h1,3'h0,2'h3,4'h2,8'h05},
    '{8'hf6,1'h0,3'h0,2'h3,4'h2,8'h02}, '{8'hf6,1'h1,3'h0,2'h3,4'h2,8'h05},
    '{8'h08,1'h0,3'h0,2'h3,4'h3,8'h02}, '{8'h08,1'h1,3'h0,2'h3,4'h3,8'h07},
    '{8'h0a,1'h1,3'h0,2'h3,4'h3,8'h06}, '{8'h0c,1'h1,3'h0,2'h3,4'h3,8'h02},
    '{8'h80,1'h0,3'h1,2'h3,4'h3,8'h02}, '{8'h80,1'h1,3'h1,2'h3,4'h3,8'h07},
    '{8'h30,1'h0,3'h0,2'h3,4'h4,8'h02}, '{8'h30,1'h1,3'h0,2'h3,4'h4,8'h07},
    '{8'h32,1'h1,3'h0,2'h3,4'h4,8'h06}, '{8'h34,1'h1,3'h0,2'h3,4'h4,8'h02},
    '{8'h80,1'h0,3'h6,2'h3,4'h4,8'h02}, '{8'h80,1'h1,3'h6,2'h3,4'h4,8'h07},
    '{8'hf6,1'h0,3'h2,2'h3,4'h5,8'h02}, '{8'hf6,1'h1,3'h2,2'h3,4'h5,8'h06},
    '{8'ha6,1'h1,3'h0,2'h3,4'h6,8'h0a}, '{8'hac,1'h1,3'h0,2'h3,4'h8,8'h05},
    '{8'h6c,1'h1,3'h0,2'h0,4'h7,8'h0f}, '{8'h6c,1'h1,3'h0,2'h1,4'h7,8'h09},
    '{8'h6c,1'h1,3'h0,2'h2,4'h7,8'h1d}, '{8'h6e,1'h1,3'h0,2'h0,4'ha,8'h0e},
    '{8'h6e,1'h1,3'h0,2'h1,4'ha,8'h08}, '{8'h6e,1'h1,3'h0,2'h2,4'ha,8'h1c},
    '{8'ha4,1'h1,3'h0,2'h3,4'h9,8'h07}, '{8'hae,1'h1,3'h0,2'h3,4'hb,8'h07},
    '{8'haa,1'h1,3'h0,2'h3,4'hc,8'h04}, '{8'hd7,1'h1,3'h0,2'h3,4'hd,8'h05},
    '{8'h80,1'h1,3'h2,2'h3,4'h0,8'h07}, '{8'hf6,1'h0,3'h7,2'h3,4'h0,8'h01}
  };

  lsd_decoder u_dut (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .INSTR(INSTR), .PROT_MODE(PROT_MODE),
    .IO_PRIV_OK(IO_PRIV_OK), .ADDR32(ADDR32), .COUNT_REG(COUNT_REG),
    .ELEM_MISMATCH(ELEM_MISMATCH), .ACCEPT(ACCEPT), .RESULT(RESULT), .BUSY(BUSY),
    .STEP(STEP), .DONE(DONE), .CLOCKS_USED(CLOCKS_USED), .ITER_LEFT(ITER_LEFT)
  );

  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    comparisons++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One request; a held request while busy must be ignored
  task automatic run(input logic [7:0] op_b, input logic [7:0] modrm, input logic rep,
                     input logic [1:0] md, input logic [31:0] cnt, input logic a32,
                     input logic mism, input logic [3:0] op, input logic [31:0] n,
                     input logic hold);
    lsd_exp_s e;
    int       k;
    e.op = op;
    e.n = n;
    e.byte_op = (op_b == 8'hd7) | ~op_b[0];
    e.chk = (op != 4'h0);
    e.dest = ~op_b[1];
    e.chk_dest = ((op_b & 8'hc4) == 8'h00) && (op != 4'h0);
    e.rep = rep && (op_b[7:1] == 7'h53);
    @(posedge CLK_SYS);
    INSTR <= '{1'b1, rep, op_b, modrm};
    PROT_MODE <= (md != 2'h0);
    IO_PRIV_OK <= (md == 2'h1);
    ADDR32 <= a32;
    COUNT_REG <= cnt;
    ELEM_MISMATCH <= mism;
    exp_q.push_back(e);
    @(posedge CLK_SYS);
    if (hold) begin
      INSTR <= '{1'b1, 1'b0, 8'hd7, 8'h00};
      repeat (2) @(posedge CLK_SYS);
    end
    INSTR.valid <= 1'b0;
    k = 0;
    do begin
      @(negedge CLK_SYS);
      k++;
    end while (ACCEPT !== 1'b1 && k < 400);
  endtask

  always @(negedge CLK_SYS) begin
    if (RSTN === 1'b1 && DONE === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0, "done without request");
      end else begin
        got = exp_q.pop_front();
        check(CLOCKS_USED + 32'h1, got.n, "clock count");
        check(32'(RESULT.op), 32'(got.op), "operation");
        check(32'(RESULT.repeated), 32'(got.rep), "repeat flag");
        check(32'(RESULT.illegal), 32'(got.op == 4'h0), "illegal flag");
        if (got.chk) check(32'(RESULT.byte_op), 32'(got.byte_op), "byte size");
        if (got.chk_dest) check(32'(RESULT.dest_is_rm), 32'(got.dest), "dest");
      end
    end
  end

  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    RSTN = 1'b0;
    INSTR = '0;
    PROT_MODE = 1'b0;
    IO_PRIV_OK = 1'b0;
    ADDR32 = 1'b0;
    COUNT_REG = 32'h0;
    ELEM_MISMATCH = 1'b0;
    r = $urandom(32'h4ad0173f);
    repeat (4) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    foreach (cases[i]) begin
      c = cases[i];
      r = $urandom;
      opc = c.opc;
      if (opc != 8'hd7) opc[0] = r[0];
      if (!c.mem && (opc & 8'hc4) == 8'h00) opc[1] = r[1];
      mode = (c.mode == 2'h3) ? (r[11] ? 2'h1 : {r[10], 1'b0}) : c.mode;
      run(opc, {c.mem ? {1'b0, r[2]} : 2'h3,
          (opc[7:1] == 7'h40 || opc[7:1] == 7'h7b) ? c.sub : r[6:4], r[9:7]},
          1'b0, mode, r, r[12], r[13], c.op, {24'h0, c.n}, 1'b0);
    end
    r = $urandom;
    run({7'h53, r[0]}, r[15:8], 1'b1, 2'h0, 32'h0, 1'b1, 1'b0, 4'h6, 32'd5, 1'b0);
    repeat (3) begin
      r = $urandom;
      nrep = 1 + int'(r[17:16]);
      run({7'h53, r[0]}, r[15:8], 1'b1, {1'b0, r[1]}, 32'(nrep), 1'b1, 1'b0, 4'h6,
          32'(5 + 9 * nrep), 1'b0);
    end
    run(8'ha7, 8'h00, 1'b1, 2'h2, 32'h0001_0002, 1'b0, 1'b0, 4'h6, 32'd23, 1'b0);
    run(8'ha6, 8'h00, 1'b1, 2'h1, 32'h5, 1'b1, 1'b1, 4'h6, 32'd14, 1'b0);
    run(8'hab, 8'h00, 1'b1, 2'h0, 32'h3, 1'b1, 1'b0, 4'hc, 32'd4, 1'b1);
    repeat (3) @(posedge CLK_SYS);
    check(32'(exp_q.size()), 32'h0, "results outstanding");
    conclude();
  end
endmodule
